// file: logic/pecirq_pkg.sv
// package of the pin edge-change interrupt block: register map, field positions, reset values, carriers
// assumes a plain register port with 8-bit data and a 4-bit word address
package pecirq_pkg;

  localparam int PECIRQ_PINS = 8;
  localparam int PECIRQ_AW = 4;
  localparam int PECIRQ_DW = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (word index on the register port)
  localparam logic [3:0] PECIRQ_OFS_RISE = 4'h0;
  localparam logic [3:0] PECIRQ_OFS_FALL = 4'h1;
  localparam logic [3:0] PECIRQ_OFS_FLAGS = 4'h2;
  localparam logic [3:0] PECIRQ_OFS_CTRL = 4'h3;
  localparam logic [3:0] PECIRQ_OFS_ISTAT = 4'h4;
  localparam logic [3:0] PECIRQ_OFS_IMASK = 4'h5;
  localparam logic [3:0] PECIRQ_OFS_PINS = 4'h6;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int PECIRQ_CTRL_MEN_BIT = 0;
  localparam int PECIRQ_CTRL_SUM_BIT = 1;
  localparam int PECIRQ_CTRL_SLEEP_BIT = 2;
  localparam int PECIRQ_IST_EDGE_BIT = 0;
  localparam int PECIRQ_IST_WAKE_BIT = 1;
  localparam int PECIRQ_IST_OVR_BIT = 2;
  localparam int PECIRQ_IST_W = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] PECIRQ_RST_RISE = 8'h00;
  localparam logic [7:0] PECIRQ_RST_FALL = 8'h00;
  localparam logic [7:0] PECIRQ_RST_FLAGS = 8'h00;
  localparam logic PECIRQ_RST_MEN = 1'b0;
  localparam logic [2:0] PECIRQ_RST_ISTAT = 3'h0;
  localparam logic [2:0] PECIRQ_RST_IMASK = 3'h0;
  localparam logic [7:0] PECIRQ_RD_IDLE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // synchroniser depth and carriers
  localparam int PECIRQ_SYNC_STAGES = 3;

  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] level;
  } pecirq_edges_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pecirq_req_t;

endpackage

// file: logic/pecirq_sync.sv
// per-pin synchroniser and edge detector for the watched pins
// assumes pins are asynchronous to the clock; reset already synchronised
`timescale 1ns/100ps
`default_nettype none
module pecirq_sync
  import pecirq_pkg::*;
#(
  parameter int PINS = PECIRQ_PINS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [PINS-1:0] pin_in,
  output pecirq_edges_t edges
);

  logic [2:0] prime_reg;
  logic [2:0] prime_next;

  ////////////////////////////////////////////////////////////////////////////
  // priming: the first accepted level after reset makes no edge
  // stage three holds no real pin sample for three edges, so the level loads from stage two meanwhile
  always_comb begin
    prime_next = {prime_reg[1:0], 1'b1};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prime_reg <= 3'h0;
    end else begin
      prime_reg <= prime_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // three stages; a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      logic [2:0] sh_reg;
      logic [2:0] sh_next;
      logic lvl_reg;
      logic lvl_next;
      always_comb begin
        sh_next = {sh_reg[1:0], pin_in[gi]};
        lvl_next = (sh_reg[2] == sh_reg[1]) ? sh_reg[2] : lvl_reg; // RULE_14
        if (!prime_reg[2]) begin
          lvl_next = sh_reg[1];
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sh_reg <= 3'h0;
          lvl_reg <= 1'b0;
        end else begin
          sh_reg <= sh_next;
          lvl_reg <= lvl_next;
        end
      end
      assign edges.rise[gi] = prime_reg[2] & lvl_next & ~lvl_reg; // RULE_14
      assign edges.fall[gi] = prime_reg[2] & ~lvl_next & lvl_reg; // RULE_14
      assign edges.level[gi] = lvl_reg;
    end
  endgenerate

endmodule
`default_nettype wire

// file: logic/pecirq_top.sv
// top of the pin edge-change interrupt block: registers, flags, interrupt and wake
// assumes a one-clock register port, a sleep level from the core, pins asynchronous
//
// Function
// RULE_01: each of the eight pins is enabled independently, alone or in any combination.
// RULE_02: with master enable clear, detection and flags run but no interrupt request; IRQ still rises from the status edge bit when its mask bit is set.
// RULE_03: rising edges are detected only where the rising enable bit is set.
// RULE_04: falling edges are detected only where the falling enable bit is set.
// RULE_05: both enables set on a pin flag edges of either polarity.
// RULE_06: an enabled edge sets the pin flag; with master enable, request raised.
// RULE_07: the summary flag is the OR of all eight pin flags.
// RULE_08: writing zero clears a flag, but an edge in that cycle keeps it set.
// RULE_09: software should clear flags with an AND mask of bits seen set.
// RULE_10: with master enable set, an enabled edge during sleep wakes the device.
// RULE_11: a sleep edge is in the flag register before wake is signalled.
// RULE_12: rise and fall enable registers are read-write and reset to zero.
// RULE_13: flags are readable, writable, set by hardware, and reset to zero.
// RULE_14: pins are synchronised and edges found by comparing successive samples.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pecirq_top
  import pecirq_pkg::*;
#(
  parameter int PINS = PECIRQ_PINS
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [PINS-1:0] WATCHED_PIN,
  input wire logic CORE_SLEEP,
  input wire logic [PECIRQ_AW-1:0] REG_ADDR,
  input wire logic [PECIRQ_DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [PECIRQ_DW-1:0] REG_RDATA,
  output logic PIN_CHANGE_IRQ,
  output logic EDGE_IRQ_SUMMARY_FLAG,
  output logic CORE_WAKE,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops

  logic [1:0] rst_sync_reg;
  logic [1:0] rst_sync_next;
  logic rst_n;

  always_comb begin
    rst_sync_next = {rst_sync_reg[0], 1'b1};
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= rst_sync_next;
    end
  end

  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // register port request bundle and decode

  pecirq_req_t req;

  assign req.addr = REG_ADDR;
  assign req.wdata = REG_WDATA;
  assign req.wr = REG_WR;
  assign req.rd = REG_RD;

  function automatic logic hit(input pecirq_req_t r, input logic [3:0] ofs, input logic strobe);
    hit = strobe && (r.addr == ofs);
  endfunction

  logic wr_rise;
  logic wr_fall;
  logic wr_flags;
  logic wr_ctrl;
  logic wr_imask;
  logic rd_istat;

  assign wr_rise = hit(req, PECIRQ_OFS_RISE, req.wr);
  assign wr_fall = hit(req, PECIRQ_OFS_FALL, req.wr);
  assign wr_flags = hit(req, PECIRQ_OFS_FLAGS, req.wr);
  assign wr_ctrl = hit(req, PECIRQ_OFS_CTRL, req.wr);
  assign wr_imask = hit(req, PECIRQ_OFS_IMASK, req.wr);
  assign rd_istat = hit(req, PECIRQ_OFS_ISTAT, req.rd);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and edge detector

  pecirq_edges_t edges;

  pecirq_sync #(
    .PINS(PINS)
  ) u_sync (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .pin_in(WATCHED_PIN),
    .edges(edges)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [PINS-1:0] rise_en_reg;
  logic [PINS-1:0] rise_en_next;
  logic [PINS-1:0] fall_en_reg;
  logic [PINS-1:0] fall_en_next;
  logic men_reg;
  logic men_next;

  always_comb begin
    rise_en_next = rise_en_reg;
    fall_en_next = fall_en_reg;
    men_next = men_reg;
    if (wr_rise) begin
      rise_en_next = req.wdata[PINS-1:0]; // RULE_12
    end
    if (wr_fall) begin
      fall_en_next = req.wdata[PINS-1:0]; // RULE_12
    end
    if (wr_ctrl) begin
      men_next = req.wdata[PECIRQ_CTRL_MEN_BIT];
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rise_en_reg <= PECIRQ_RST_RISE[PINS-1:0]; // RULE_12
      fall_en_reg <= PECIRQ_RST_FALL[PINS-1:0]; // RULE_12
      men_reg <= PECIRQ_RST_MEN;
    end else begin
      rise_en_reg <= rise_en_next;
      fall_en_reg <= fall_en_next;
      men_reg <= men_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin flags; a detected edge beats the write in the same cycle

  logic [PINS-1:0] hit_edge;
  logic [PINS-1:0] flags_reg;
  logic [PINS-1:0] flags_next;
  logic summary;

  // each pin enabled on its own, either polarity or both
  assign hit_edge = (edges.rise & rise_en_reg) | (edges.fall & fall_en_reg); // RULE_01 RULE_03 RULE_04 RULE_05

  always_comb begin
    flags_next = flags_reg;
    if (wr_flags) begin
      flags_next = req.wdata[PINS-1:0]; // RULE_13
    end
    flags_next = flags_next | hit_edge; // RULE_06 RULE_08 RULE_02
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= PECIRQ_RST_FLAGS[PINS-1:0]; // RULE_13
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign summary = |flags_reg; // RULE_07

  ////////////////////////////////////////////////////////////////////////////
  // request and wake outputs, registered from flag state

  logic sleep_meta_reg;
  logic sleep_sync_reg;
  logic sleep_s3_reg;
  logic [2:0] sleep_sh_next;
  logic sleep_lvl_reg;
  logic sleep_lvl_next;
  logic irq_req_reg;
  logic irq_req_next;
  logic sum_out_reg;
  logic wake_reg;
  logic wake_next;

  always_comb begin
    sleep_sh_next = {sleep_sync_reg, sleep_meta_reg, CORE_SLEEP};
    sleep_lvl_next = sleep_lvl_reg;
    // only stages two and three decide; stage one may be metastable
    if (sleep_s3_reg == sleep_sync_reg) begin
      sleep_lvl_next = sleep_s3_reg;
    end
    // master enable gates the request and the wake, never detection
    irq_req_next = men_reg & (|flags_next); // RULE_02 RULE_06
    // flags_next is stored on the same edge that wake rises
    wake_next = sleep_lvl_reg & men_reg & (|flags_next); // RULE_10 RULE_11
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sleep_meta_reg <= 1'b0;
      sleep_sync_reg <= 1'b0;
      sleep_s3_reg <= 1'b0;
      sleep_lvl_reg <= 1'b0;
      irq_req_reg <= 1'b0;
      sum_out_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      sleep_meta_reg <= sleep_sh_next[0];
      sleep_sync_reg <= sleep_sh_next[1];
      sleep_s3_reg <= sleep_sh_next[2];
      sleep_lvl_reg <= sleep_lvl_next;
      irq_req_reg <= irq_req_next;
      sum_out_reg <= |flags_next; // RULE_07
      wake_reg <= wake_next;
    end
  end

  assign PIN_CHANGE_IRQ = irq_req_reg;
  assign EDGE_IRQ_SUMMARY_FLAG = sum_out_reg;
  assign CORE_WAKE = wake_reg;

  ////////////////////////////////////////////////////////////////////////////
  // block interrupt: sticky status cleared by its read, masked onto IRQ

  logic [PECIRQ_IST_W-1:0] ev;
  logic [PECIRQ_IST_W-1:0] istat_reg;
  logic [PECIRQ_IST_W-1:0] istat_next;
  logic [PECIRQ_IST_W-1:0] imask_reg;
  logic [PECIRQ_IST_W-1:0] imask_next;
  logic irq_reg;
  logic irq_next;

  always_comb begin
    ev = '0;
    ev[PECIRQ_IST_EDGE_BIT] = |hit_edge;
    ev[PECIRQ_IST_WAKE_BIT] = wake_next & ~wake_reg;
    ev[PECIRQ_IST_OVR_BIT] = |(hit_edge & flags_reg);
    istat_next = istat_reg;
    if (rd_istat) begin
      istat_next = '0;
    end
    // an event in the clearing read cycle survives
    istat_next = istat_next | ev;
    imask_next = imask_reg;
    if (wr_imask) begin
      imask_next = req.wdata[PECIRQ_IST_W-1:0];
    end
    irq_next = |(istat_next & imask_next);
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      istat_reg <= PECIRQ_RST_ISTAT;
      imask_reg <= PECIRQ_RST_IMASK;
      irq_reg <= 1'b0;
    end else begin
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      irq_reg <= irq_next;
    end
  end

  assign IRQ = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read data: valid only in the cycle after the read strobe

  logic [PECIRQ_DW-1:0] rdata_reg;
  logic [PECIRQ_DW-1:0] rdata_next;
  logic [PECIRQ_DW-1:0] ctrl_view;

  always_comb begin
    ctrl_view = '0;
    ctrl_view[PECIRQ_CTRL_MEN_BIT] = men_reg;
    ctrl_view[PECIRQ_CTRL_SUM_BIT] = summary; // RULE_07
    ctrl_view[PECIRQ_CTRL_SLEEP_BIT] = sleep_lvl_reg;
    rdata_next = PECIRQ_RD_IDLE;
    if (req.rd) begin
      case (req.addr)
        PECIRQ_OFS_RISE: begin
          rdata_next[PINS-1:0] = rise_en_reg; // RULE_12
        end
        PECIRQ_OFS_FALL: begin
          rdata_next[PINS-1:0] = fall_en_reg; // RULE_12
        end
        PECIRQ_OFS_FLAGS: begin
          rdata_next[PINS-1:0] = flags_reg; // RULE_13
        end
        PECIRQ_OFS_CTRL: begin
          rdata_next = ctrl_view;
        end
        PECIRQ_OFS_ISTAT: begin
          rdata_next[PECIRQ_IST_W-1:0] = istat_reg;
        end
        PECIRQ_OFS_IMASK: begin
          rdata_next[PECIRQ_IST_W-1:0] = imask_reg;
        end
        PECIRQ_OFS_PINS: begin
          rdata_next[PINS-1:0] = edges.level;
        end
        default: begin
          rdata_next = PECIRQ_RD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= PECIRQ_RD_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA = rdata_reg;

endmodule
`default_nettype wire

// file: tb/pecirq_assertions.sv
// checker: port relations of the edge-change interrupt block
// assumes a bind onto pecirq_top, one clock, RSTN active low
`timescale 1ns/100ps
`default_nettype none
module pecirq_chk
  import pecirq_pkg::*;
#(
  parameter int PINS = PECIRQ_PINS
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [PINS-1:0] WATCHED_PIN,
  input wire logic CORE_SLEEP,
  input wire logic [PECIRQ_AW-1:0] REG_ADDR,
  input wire logic [PECIRQ_DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [PECIRQ_DW-1:0] REG_RDATA,
  input wire logic PIN_CHANGE_IRQ,
  input wire logic EDGE_IRQ_SUMMARY_FLAG,
  input wire logic CORE_WAKE,
  input wire logic IRQ
);
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);
  logic [PINS-1:0] pin_reg;
  logic [3:0] quiet_reg;
  logic [3:0] quiet_next;
  // cycles since a pin last moved, saturating
  always_comb begin
    quiet_next = (WATCHED_PIN != pin_reg) ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hf};
  end
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_reg <= '0;
      quiet_reg <= 4'h0;
    end else begin
      pin_reg <= WATCHED_PIN;
      quiet_reg <= quiet_next;
    end
  end
  ////////////////
  property p_rd_idle;
    !$past(REG_RD) |-> REG_RDATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_sum_rd;
    $past(REG_RD && REG_ADDR == PECIRQ_OFS_FLAGS) |-> (REG_RDATA != 8'h00) == $past(EDGE_IRQ_SUMMARY_FLAG);
  endproperty
  a_sum_rd: assert property (p_sum_rd) else $error("summary differs from flags");
  property p_req_flag;
    PIN_CHANGE_IRQ |-> EDGE_IRQ_SUMMARY_FLAG;
  endproperty
  a_req_flag: assert property (p_req_flag) else $error("request without flag");
  property p_wake;
    CORE_WAKE |-> PIN_CHANGE_IRQ;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without request");
  property p_set_cause;
    $rose(EDGE_IRQ_SUMMARY_FLAG) |-> $past(REG_WR) || quiet_reg <= 4'h7;
  endproperty
  a_set_cause: assert property (p_set_cause) else $error("flag set without pin change");
  property p_sum_hold;
    $fell(EDGE_IRQ_SUMMARY_FLAG) |-> $past(REG_WR && REG_ADDR == PECIRQ_OFS_FLAGS);
  endproperty
  a_sum_hold: assert property (p_sum_hold) else $error("flag lost without write");
  property p_req_rise;
    $rose(PIN_CHANGE_IRQ) |-> $rose(EDGE_IRQ_SUMMARY_FLAG) || $past(REG_WR && REG_ADDR == PECIRQ_OFS_CTRL, 2);
  endproperty
  a_req_rise: assert property (p_req_rise) else $error("request rose without cause");
  property p_clr;
    $past(REG_WR && REG_ADDR == PECIRQ_OFS_FLAGS && REG_WDATA == 8'h00) && quiet_reg > 4'h8
      |-> !EDGE_IRQ_SUMMARY_FLAG;
  endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared");
  c_req: cover property ($rose(PIN_CHANGE_IRQ));
  c_wake: cover property ($rose(CORE_WAKE));
  c_irq: cover property ($rose(IRQ));
endmodule
bind pecirq_top pecirq_chk #(.PINS(PINS)) u_chk (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .WATCHED_PIN(WATCHED_PIN),
  .CORE_SLEEP(CORE_SLEEP), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .PIN_CHANGE_IRQ(PIN_CHANGE_IRQ), .EDGE_IRQ_SUMMARY_FLAG(EDGE_IRQ_SUMMARY_FLAG),
  .CORE_WAKE(CORE_WAKE), .IRQ(IRQ));
`default_nettype wire

// file: tb/pecirq_pins.sv
// partner: the watched pin levels and the core sleep state
// assumes level and sleep requests from the bench; a wake ends sleep
`timescale 1ns/100ps
`default_nettype none
module pecirq_pins
  import pecirq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] lvl,
  input wire logic slp,
  input wire logic wake,
  output logic [7:0] pins = 8'h00,
  output logic sleep = 1'b0
);
  always_ff @(posedge clk) begin
    pins <= lvl;
    // core stays asleep until the block wakes it
    sleep <= rst_n & (sleep | slp) & ~wake;
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// testbench: random and corner traffic on the edge-change interrupt block
// assumes the pin partner model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module tb_top import pecirq_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] lvl = 8'h00;
  logic slp = 1'b0;
  logic [7:0] rdata;
  logic [7:0] pins;
  logic req, sum, wake, irq, sleep;
  int n_mismatch = 0;
  int check_count = 0;
  always #2 clk = ~clk;
  pecirq_pins part (.clk(clk), .rst_n(rstn), .lvl(lvl), .slp(slp), .wake(wake), .pins(pins), .sleep(sleep));
  pecirq_top dut (.SYS_CLK(clk), .RSTN(rstn), .WATCHED_PIN(pins), .CORE_SLEEP(sleep), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .PIN_CHANGE_IRQ(req),
    .EDGE_IRQ_SUMMARY_FLAG(sum), .CORE_WAKE(wake), .IRQ(irq));
  ////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rreg(a, d);
    chk(d, exp);
  endtask
  task automatic do_reset;
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [7:0] exp_edge(input logic [7:0] o, n, r, f);
    return (~o & n & r) | (o & ~n & f);
  endfunction
  ////////////////
  initial begin
    logic [7:0] d, r, f, o, n, e;
    logic [2:0] m;
    int k;
    int i;
    k = $urandom(8184);
    do_reset();
    for (k = 0; k < 16; k++) rchk(k[3:0], 8'h00);
    for (k = 0; k < 2; k++) begin
      d = 8'($urandom);
      wreg(k[3:0], d);
      rchk(k[3:0], d);
    end
    wreg(PECIRQ_OFS_FLAGS, 8'h5a);
    rchk(PECIRQ_OFS_FLAGS, 8'h5a);
    rchk(PECIRQ_OFS_CTRL, 8'h02);
    chk({7'h00, req}, 8'h00);
    wreg(PECIRQ_OFS_FLAGS, 8'h00);
    $display("test registers done");
    for (k = 0; k < 24; k++) begin
      r = 8'($urandom);
      f = 8'($urandom);
      m = 3'($urandom);
      if (k == 0) begin
        r = 8'h80;
        f = 8'h00;
      end
      if (k == 1) begin
        r = 8'hff;
        f = 8'hff;
      end
      wreg(PECIRQ_OFS_RISE, r);
      wreg(PECIRQ_OFS_FALL, f);
      wreg(PECIRQ_OFS_CTRL, {7'h00, k[0]});
      wreg(PECIRQ_OFS_IMASK, {5'h00, m});
      rreg(PECIRQ_OFS_ISTAT, d);
      o = lvl;
      n = (k == 0) ? 8'hff : 8'($urandom);
      lvl <= n;
      repeat (8) @(posedge clk);
      e = exp_edge(o, n, r, f);
      rchk(PECIRQ_OFS_PINS, n);
      chk({7'h00, sum}, {7'h00, |e});
      chk({7'h00, req}, {7'h00, k[0] & |e});
      chk({7'h00, irq}, {7'h00, m[0] & |e});
      rchk(PECIRQ_OFS_ISTAT, {7'h00, |e});
      chk({7'h00, irq}, 8'h00);
      rreg(PECIRQ_OFS_FLAGS, d);
      chk(d, e);
      rreg(PECIRQ_OFS_FLAGS, o);
      wreg(PECIRQ_OFS_FLAGS, o & (d ^ 8'hff));
      rchk(PECIRQ_OFS_FLAGS, 8'h00);
    end
    $display("test random edges done");
    wreg(PECIRQ_OFS_RISE, 8'hff);
    wreg(PECIRQ_OFS_FALL, 8'hff);
    rreg(PECIRQ_OFS_ISTAT, d);
    for (k = 0; k < 2; k++) begin
      wreg(PECIRQ_OFS_CTRL, {7'h00, k[0]});
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      repeat (6) @(posedge clk);
      rchk(PECIRQ_OFS_CTRL, {5'h00, 2'b10, k[0]});
      lvl <= ~lvl;
      for (i = 0; i < 12 && wake !== 1'b1; i++) begin
        @(posedge clk);
        #1;
      end
      chk({7'h00, wake}, {7'h00, k[0]});
      chk({7'h00, sum}, 8'h01);
      rchk(PECIRQ_OFS_FLAGS, 8'hff);
      rchk(PECIRQ_OFS_ISTAT, {6'h00, k[0], 1'b1});
      wreg(PECIRQ_OFS_FLAGS, 8'h00);
    end
    repeat (6) @(posedge clk);
    rchk(PECIRQ_OFS_CTRL, 8'h01);
    $display("test sleep done");
    wreg(PECIRQ_OFS_CTRL, 8'h00);
    for (k = 0; k < 3; k++) begin
      lvl <= lvl ^ 8'h01;
      repeat (k + 1) @(posedge clk);
      wreg(PECIRQ_OFS_FLAGS, 8'h00);
      repeat (6) @(posedge clk);
      rchk(PECIRQ_OFS_FLAGS, 8'h01);
      wreg(PECIRQ_OFS_FLAGS, 8'h00);
    end
    $display("test clear race done");
    lvl <= lvl ^ 8'h01;
    repeat (8) @(posedge clk);
    rreg(PECIRQ_OFS_ISTAT, d);
    lvl <= lvl ^ 8'h01;
    repeat (8) @(posedge clk);
    wreg(PECIRQ_OFS_CTRL, 8'h01);
    rchk(PECIRQ_OFS_ISTAT, 8'h05);
    chk({7'h00, req}, 8'h01);
    do_reset();
    rchk(PECIRQ_OFS_FLAGS, 8'h00);
    rchk(PECIRQ_OFS_RISE, 8'h00);
    chk({7'h00, sum}, 8'h00);
    $display("test second reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
